// ==== hw/dem_frame_counter.sv ====
// Frame group counter: counts frame starts, wraps at programmed length
`timescale 1ns/1ns
module dem_frame_counter (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic frame_start_i, // New frame start pulse
  input wire logic [15:0] length_i, // Frames per group
  output logic wrap_o // Group complete pulse
);
  import dem_pkg::*;

  dem_frame_state_t st_reg;
  dem_frame_state_t st_next;
  logic [15:0] inc;

  always_comb begin
    st_next = st_reg;
    st_next.wrap = 1'b0;
    inc = st_reg.cnt + 16'h0001;
    if (frame_start_i) begin
      if (inc == length_i) begin
        st_next.cnt = '0; // [R10]
        st_next.wrap = 1'b1; // [R10]
      end else begin
        st_next.cnt = inc; // [R9]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wrap_o = st_reg.wrap;

  a_frame_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    frame_start_i && (st_reg.cnt + 16'h0001 != length_i)
      |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001) // [R9]
    else $error("frame counter did not step");
  a_frame_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    frame_start_i && (st_reg.cnt + 16'h0001 == length_i)
      |=> st_reg.cnt == 16'h0000 && wrap_o) // [R10]
    else $error("frame counter did not wrap");
endmodule

// ==== hw/dem_prescaler.sv ====
// Watchdog prescaler: one-cycle step enable every 64 << code clocks, codes above 1011 taken as 1011
`timescale 1ns/1ns
module dem_prescaler (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic clear_i, // Restart the period
  input wire logic [3:0] code_i, // Prescale code
  output logic tick_o // Step enable pulse
);
  import dem_pkg::*;

  dem_presc_state_t st_reg;
  dem_presc_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (clear_i) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= dem_presc_last(code_i)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1; // [R7]
    end else begin
      st_next.cnt = st_reg.cnt + 17'h0_0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

  a_tick_at_last: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick_o |-> $past(st_reg.cnt) >= $past(dem_presc_last(code_i))) // [R7]
    else $error("prescale step outside period end");
endmodule

// ==== hw/dem_top.sv ====
// DSP execution monitor: watchdog, error PC capture, frame group interrupts
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "dem_cfg.svh"
module dem_top (
  input wire logic sys_clk_i, // 250 MHz system clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [15:0] addr_i, // Register address
  input wire logic [15:0] wr_data_i, // Register write data
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  output logic [15:0] rd_data_o, // Read data, cycle after strobe
  input wire logic frame_start_i, // Frame start pulse from sequencer
  input wire logic pc_restart_i, // Program jumped back to start
  input wire logic [23:0] pc_i, // Live program counter
  input wire logic [15:0] exec_pc_i, // Execute-stage program count
  input wire logic sw_error_i, // Software error pulse
  output logic wd_error_o, // Watchdog error pulse to fault manager
  output logic wd_fault_o, // Sticky watchdog fault flag
  output logic block_irq_o, // Block interrupt pulse
  output logic irq_o // Level interrupt, OR of status bits enabled in the mask
);
  import dem_pkg::*;

  dem_top_state_t r;
  dem_top_state_t n;
  logic wd_tick;
  logic frame_wrap;

  dem_prescaler u_presc (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(pc_restart_i),
    .code_i(r.presc),
    .tick_o(wd_tick)
  );

  dem_frame_counter u_frame (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .frame_start_i(frame_start_i),
    .length_i(r.blk_len),
    .wrap_o(frame_wrap)
  );

  always_comb begin
    n = r;
    n.wd_err = 1'b0;
    n.blk_irq = 1'b0;
    n.rd_data = '0;

    // Register writes
    if (wr_en_i) begin
      case (addr_i)
        `DEM_OFS_ERR_PC: n.err_pc = wr_data_i;
        `DEM_OFS_RELOAD: n.reload = wr_data_i[`DEM_RELOAD_W-1:0]; // [R5]
        `DEM_OFS_PRESC: n.presc = wr_data_i[`DEM_PRESC_W-1:0];
        `DEM_OFS_BLK_EN: n.blk_en = wr_data_i[0];
        `DEM_OFS_BLK_LEN: n.blk_len = wr_data_i;
        `DEM_OFS_FAULT: begin
          if (wr_data_i[0]) begin
            n.fault = 1'b0;
          end
        end
        `DEM_OFS_IRQ_STAT: n.irq_stat = r.irq_stat & ~wr_data_i[`DEM_IRQ_N-1:0];
        `DEM_OFS_IRQ_MASK: n.irq_mask = wr_data_i[`DEM_IRQ_N-1:0];
        default: begin
        end
      endcase
    end

    // Hardware capture wins over a software write
    if (sw_error_i) begin
      n.err_pc = exec_pc_i; // [R1]
      n.irq_stat[`DEM_IRQ_SWE] = 1'b1;
    end

    // Watchdog
    if (pc_restart_i) begin
      n.wd_cnt = r.reload; // [R3]
      n.wd_state = DEM_WD_RUN;
    end else begin
      case (r.wd_state)
        DEM_WD_IDLE: begin
        end
        DEM_WD_RUN: begin
          if (r.wd_cnt == '0) begin
            n.wd_state = DEM_WD_EXPIRED; // [R13]
            n.wd_err = 1'b1; // [R4]
          end else if (wd_tick) begin
            n.wd_cnt = r.wd_cnt - 13'h0001; // [R2] [R6]
          end
        end
        DEM_WD_EXPIRED: begin
          n.wd_cnt = '0; // [R13]
        end
        default: n.wd_state = DEM_WD_IDLE;
      endcase
    end

    if (n.wd_err) begin
      n.fault = 1'b1; // [R12]
      n.irq_stat[`DEM_IRQ_WD] = 1'b1;
    end

    // Frame group interrupt
    if (frame_wrap && r.blk_en) begin
      n.blk_irq = 1'b1; // [R8] [R10]
      n.irq_stat[`DEM_IRQ_BLK] = 1'b1;
    end

    n.irq = |(n.irq_stat & n.irq_mask);

    // Register reads, answer in the next cycle only
    if (rd_en_i) begin
      case (addr_i)
        `DEM_OFS_ERR_PC: n.rd_data = r.err_pc;
        `DEM_OFS_RELOAD: n.rd_data = {3'h0, r.reload}; // [R5]
        `DEM_OFS_PRESC: n.rd_data = {12'h000, r.presc};
        `DEM_OFS_BLK_EN: n.rd_data = {15'h0000, r.blk_en};
        `DEM_OFS_BLK_LEN: n.rd_data = r.blk_len;
        `DEM_OFS_PC_HIGH: n.rd_data = {8'h00, pc_i[23:16]}; // [R11]
        `DEM_OFS_FAULT: n.rd_data = {15'h0000, r.fault};
        `DEM_OFS_IRQ_STAT: n.rd_data = {13'h0000, r.irq_stat};
        `DEM_OFS_IRQ_MASK: n.rd_data = {13'h0000, r.irq_mask};
        default: n.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{
        err_pc: `DEM_RST_ERR_PC,
        reload: `DEM_RST_RELOAD,
        presc: `DEM_RST_PRESC,
        blk_en: `DEM_RST_BLK_EN,
        blk_len: `DEM_RST_BLK_LEN,
        irq_stat: '0,
        irq_mask: `DEM_RST_IRQ_MASK,
        fault: 1'b0,
        wd_cnt: '0,
        wd_state: DEM_WD_IDLE,
        wd_err: 1'b0,
        blk_irq: 1'b0,
        irq: 1'b0,
        rd_data: '0
      };
    end else begin
      r <= n;
    end
  end

  assign rd_data_o = r.rd_data;
  assign wd_error_o = r.wd_err;
  assign wd_fault_o = r.fault;
  assign block_irq_o = r.blk_irq;
  assign irq_o = r.irq;

  // Checking helpers: clocks since last step, one behind the prescale count
  logic [17:0] gap_q;
  logic presc_dirty;
  logic presc_wr;
  assign presc_wr = wr_en_i && (addr_i == `DEM_OFS_PRESC);

  // A code change mid-period leaves one irregular step
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= '1;
      presc_dirty <= 1'b0;
    end else begin
      if (pc_restart_i) begin
        gap_q <= '1;
      end else if (wd_tick) begin
        gap_q <= '0;
      end else begin
        gap_q <= gap_q + 18'h0_0001;
      end
      if (presc_wr) begin
        presc_dirty <= 1'b1;
      end else if (pc_restart_i || wd_tick) begin
        presc_dirty <= 1'b0;
      end
    end
  end

  default clocking dem_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_capture_exec_pc: assert property ( // [R1]
    sw_error_i |=> r.err_pc == $past(exec_pc_i))
    else $error("error PC not captured");
  a_wd_count_step: assert property ( // [R2]
    r.wd_state == DEM_WD_RUN && wd_tick && r.wd_cnt != '0 && !pc_restart_i
      |=> r.wd_cnt == $past(r.wd_cnt) - 13'h0001)
    else $error("watchdog did not step down");
  a_wd_reload_load: assert property ( // [R3]
    pc_restart_i |=> r.wd_cnt == $past(r.reload) && r.wd_state == DEM_WD_RUN)
    else $error("watchdog not reloaded");
  a_wd_expiry_error: assert property ( // [R4]
    r.wd_state == DEM_WD_RUN && r.wd_cnt == '0 && !pc_restart_i |=> wd_error_o)
    else $error("watchdog expiry not reported");
  a_reload_field_width: assert property ( // [R5]
    rd_en_i && addr_i == `DEM_OFS_RELOAD
      |=> rd_data_o == {3'h0, $past(r.reload)})
    else $error("reload readback wrong");
  a_wd_hold_between: assert property ( // [R6]
    r.wd_state == DEM_WD_RUN && !wd_tick && !pc_restart_i && r.wd_cnt != '0
      |=> r.wd_cnt == $past(r.wd_cnt))
    else $error("watchdog stepped without enable");
  a_presc_period: assert property ( // [R7]
    wd_tick && !presc_dirty
      |-> gap_q == {1'b0, dem_presc_last(r.presc)})
    else $error("prescale period wrong");
  a_blk_irq_gate: assert property ( // [R8]
    frame_wrap |=> block_irq_o == $past(r.blk_en))
    else $error("block interrupt gating wrong");
  a_pc_upper_read: assert property ( // [R11]
    rd_en_i && addr_i == `DEM_OFS_PC_HIGH |=> rd_data_o == {8'h00, $past(pc_i[23:16])})
    else $error("program counter byte wrong");
  a_fault_sticky: assert property ( // [R12]
    wd_fault_o && !(wr_en_i && addr_i == `DEM_OFS_FAULT && wr_data_i[0]) |=> wd_fault_o)
    else $error("fault flag dropped");
  a_fault_on_error: assert property ( // [R12]
    wd_error_o |-> wd_fault_o)
    else $error("fault flag not set on error");
  a_expire_once: assert property ( // [R13]
    wd_error_o && !pc_restart_i ##1 !pc_restart_i |=> !wd_error_o && r.wd_cnt == '0)
    else $error("watchdog error repeated");
  a_expired_hold: assert property ( // [R13]
    r.wd_state == DEM_WD_EXPIRED && !pc_restart_i
      |=> r.wd_state == DEM_WD_EXPIRED && r.wd_cnt == '0 && !wd_error_o)
    else $error("expired watchdog did not hold");
  a_idle_quiet: assert property ( // [R2]
    r.wd_state == DEM_WD_IDLE && !pc_restart_i
      |=> r.wd_state == DEM_WD_IDLE && !wd_error_o)
    else $error("watchdog counted before first restart");
  a_wd_status_set: assert property ( // [R4]
    wd_error_o |-> r.irq_stat[`DEM_IRQ_WD])
    else $error("watchdog status bit not set");
  a_swe_status_set: assert property ( // [R1]
    sw_error_i |=> r.irq_stat[`DEM_IRQ_SWE])
    else $error("software error status bit not set");
  a_blk_status_set: assert property ( // [R10]
    frame_wrap && r.blk_en |=> r.irq_stat[`DEM_IRQ_BLK])
    else $error("block status bit not set");
  a_blk_gated_off: assert property ( // [R8]
    !r.blk_en |=> !block_irq_o)
    else $error("block interrupt while disabled");
  a_fault_clear: assert property ( // [R12]
    wr_en_i && addr_i == `DEM_OFS_FAULT && wr_data_i[0] && !n.wd_err |=> !wd_fault_o)
    else $error("fault flag not cleared");
  a_rd_quiet: assert property ( // [R11]
    !rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data outside answer cycle");
  a_presc_read: assert property ( // [R7]
    rd_en_i && addr_i == `DEM_OFS_PRESC |=> rd_data_o == {12'h000, $past(r.presc)})
    else $error("prescale readback wrong");

  c_wd_expiry: cover property (wd_error_o);
  c_block_irq: cover property (block_irq_o && irq_o);
  c_sw_capture: cover property (sw_error_i ##2 rd_en_i && addr_i == `DEM_OFS_ERR_PC);
  c_wd_reload: cover property (pc_restart_i ##1 r.wd_state == DEM_WD_RUN);
  c_block_gated: cover property (frame_wrap && !r.blk_en);
endmodule

// ==== include/dem_cfg.svh ====
// Constants of the DSP execution monitor
//
// Behaviour
// R1: A software error stores the execute-stage program count into a 16-bit capture register.
// R2: Watchdog counter starts at the reload value and steps down by one.
// R3: Each program restart reloads the watchdog counter to its programmed maximum.
// R4: Counter reaching zero before a reload raises a watchdog error to the fault manager.
// R5: Reload value is a 13-bit read/write field, bits 12 to 0, reset zero.
// R6: Total timeout in clocks is reload value times the selected prescale factor.
// R7: Prescale code 0000 steps every 64 clocks, doubling per code up to 1011.
// R8: Bit 0 of the frame group enable register gates block interrupts; reset zero.
// R9: Each frame start pulse increments the frame counter.
// R10: Frame counter equal to programmed length gives a block interrupt and returns to zero.
// R11: Bits 23 to 16 of the live program counter read back in bits 7 to 0.
// R12: A watchdog error sets a sticky fault flag until software clears it.
// R13: After expiry the counter holds at zero and errors once until the next reload.
`ifndef DEM_CFG_SVH
`define DEM_CFG_SVH

`define DEM_ADDR_W 16
`define DEM_DATA_W 16
`define DEM_PC_W 24
`define DEM_RELOAD_W 13
`define DEM_PRESC_W 4
`define DEM_PCNT_W 17
`define DEM_IRQ_N 3

`define DEM_OFS_ERR_PC 16'hF432
`define DEM_OFS_RELOAD 16'hF443
`define DEM_OFS_PRESC 16'hF444
`define DEM_OFS_BLK_EN 16'hF450
`define DEM_OFS_BLK_LEN 16'hF451
`define DEM_OFS_PC_HIGH 16'hF460
`define DEM_OFS_FAULT 16'hF470
`define DEM_OFS_IRQ_STAT 16'hF471
`define DEM_OFS_IRQ_MASK 16'hF472

`define DEM_RST_ERR_PC 16'h0000
`define DEM_RST_RELOAD 13'h0000
`define DEM_RST_PRESC 4'h0
`define DEM_RST_BLK_EN 1'b0
`define DEM_RST_BLK_LEN 16'h0000
`define DEM_RST_IRQ_MASK 3'h0

`define DEM_PRESC_BASE 18'h0_0040
`define DEM_PRESC_MAX 4'hB

`define DEM_IRQ_WD 0
`define DEM_IRQ_BLK 1
`define DEM_IRQ_SWE 2

`endif

// ==== include/dem_pkg.sv ====
// Types and shared decode of the DSP execution monitor
`include "dem_cfg.svh"
package dem_pkg;

  typedef enum logic [1:0] {
    DEM_WD_IDLE = 2'b00,
    DEM_WD_RUN = 2'b01,
    DEM_WD_EXPIRED = 2'b11
  } dem_wd_state_t;

  typedef struct packed {
    logic [`DEM_PCNT_W-1:0] cnt;
    logic tick;
  } dem_presc_state_t;

  typedef struct packed {
    logic [`DEM_DATA_W-1:0] cnt;
    logic wrap;
  } dem_frame_state_t;

  typedef struct packed {
    logic [`DEM_DATA_W-1:0] err_pc;
    logic [`DEM_RELOAD_W-1:0] reload;
    logic [`DEM_PRESC_W-1:0] presc;
    logic blk_en;
    logic [`DEM_DATA_W-1:0] blk_len;
    logic [`DEM_IRQ_N-1:0] irq_stat;
    logic [`DEM_IRQ_N-1:0] irq_mask;
    logic fault;
    logic [`DEM_RELOAD_W-1:0] wd_cnt;
    dem_wd_state_t wd_state;
    logic wd_err;
    logic blk_irq;
    logic irq;
    logic [`DEM_DATA_W-1:0] rd_data;
  } dem_top_state_t;

  // Last count of one prescale period; codes above the top one clamp
  function automatic logic [`DEM_PCNT_W-1:0] dem_presc_last(
    input logic [`DEM_PRESC_W-1:0] code);
    logic [`DEM_PRESC_W-1:0] c;
    logic [`DEM_PCNT_W:0] period;
    c = (code > `DEM_PRESC_MAX) ? `DEM_PRESC_MAX : code;
    period = `DEM_PRESC_BASE << c;
    dem_presc_last = period[`DEM_PCNT_W-1:0] - 17'h0_0001;
  endfunction

endpackage

// ==== tb/dem_seq_model.sv ====
// Behavioural model of the DSP core sequencer that feeds the monitor
`timescale 1ns/1ns
module dem_seq_model (
  input wire logic sys_clk_i, // System clock
  output logic frame_start_o, // Frame start pulse
  output logic pc_restart_o, // Program restart pulse
  output logic [23:0] pc_o, // Live program counter
  output logic [15:0] exec_pc_o, // Execute-stage count
  output logic sw_error_o // Software error pulse
);
  initial begin
    frame_start_o = 1'b0;
    pc_restart_o = 1'b0;
    pc_o = 24'h00_0000;
    exec_pc_o = 16'h0000;
    sw_error_o = 1'b0;
  end
  task automatic frame();
    @(posedge sys_clk_i);
    frame_start_o <= 1'b1;
    @(posedge sys_clk_i);
    frame_start_o <= 1'b0;
  endtask
  task automatic restart();
    @(posedge sys_clk_i);
    pc_restart_o <= 1'b1;
    @(posedge sys_clk_i);
    pc_restart_o <= 1'b0;
  endtask
  // Count moves on after the error so a late capture shows up
  task automatic sw_err(input logic [15:0] v);
    @(posedge sys_clk_i);
    exec_pc_o <= v;
    sw_error_o <= 1'b1;
    @(posedge sys_clk_i);
    exec_pc_o <= ~v;
    sw_error_o <= 1'b0;
  endtask
  task automatic set_pc(input logic [23:0] v);
    @(posedge sys_clk_i);
    pc_o <= v;
  endtask
endmodule

// ==== tb/dem_top_tb.sv ====
// Self-checking testbench of the DSP execution monitor
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module dem_top_tb;
  typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] r;} dem_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [15:0] rd_data_o;
  logic frame_start_i, pc_restart_i, sw_error_i;
  logic [23:0] pc_i;
  logic [15:0] exec_pc_i;
  logic wd_error_o, wd_fault_o, block_irq_o, irq_o;
  int err_count = 0;
  int n_checks = 0;
  int n;
  logic [7:0] hits;
  dem_row_t rows[8] = '{
    '{16'hF443, 16'hFFFF, 16'h1FFF}, '{16'hF444, 16'hFFFF, 16'h000F},
    '{16'hF450, 16'hFFFF, 16'h0001}, '{16'hF451, 16'h1234, 16'h1234},
    '{16'hF432, 16'hBEEF, 16'hBEEF}, '{16'hF460, 16'hFFFF, 16'h005A},
    '{16'hF472, 16'hFFFF, 16'h0007}, '{16'hF400, 16'hFFFF, 16'h0000}};

  always #2 sys_clk_i = ~sys_clk_i;

  dem_seq_model SEQ (
    .sys_clk_i(sys_clk_i), .frame_start_o(frame_start_i), .pc_restart_o(pc_restart_i),
    .pc_o(pc_i), .exec_pc_o(exec_pc_i), .sw_error_o(sw_error_i));
  dem_top DUT (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .frame_start_i(frame_start_i), .pc_restart_i(pc_restart_i), .pc_i(pc_i),
    .exec_pc_i(exec_pc_i), .sw_error_i(sw_error_i), .wd_error_o(wd_error_o),
    .wd_fault_o(wd_fault_o), .block_irq_o(block_irq_o), .irq_o(irq_o));

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  // Cycles from the restart edge to the watchdog error pulse
  task automatic wd_time(input logic [15:0] r, input logic [15:0] c, input int pre);
    wr(16'hF443, r);
    wr(16'hF444, c);
    if (pre > 0) begin
      SEQ.restart();
      tick(pre);
    end
    SEQ.restart();
    n = 0;
    do begin
      tick(1);
      n++;
    end while (wd_error_o !== 1'b1 && n < 70000);
  endtask
  task automatic frames(input int k, input logic e);
    repeat (k) begin
      SEQ.frame();
      tick(1);
    end
    `CHK(block_irq_o, e)
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #360_000;
    err_count++;
    test_done();
  end

  initial begin
    logic [15:0] d;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      `CHK(d, 16'h0000)
    end
    SEQ.set_pc(24'h5A_1234);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK(d, rows[i].r)
    end
    // Every prescale code whose period fits the run
    for (int c = 0; c < 10; c++) begin
      wd_time(16'h0001, c[15:0], 0);
      `CHK(n, (64 << c) + 2)
    end
    wd_time(16'h0003, 16'h0000, 0);
    `CHK(n, 194)
    wd_time(16'h0000, 16'h0000, 0);
    `CHK(n, 1)
    wd_time(16'h0002, 16'h0000, 100);
    `CHK(n, 130)
    hits = 8'h00;
    repeat (200) begin
      tick(1);
      hits = hits + {7'h00, wd_error_o};
    end
    `CHK(hits, 8'h00)
    `CHK(wd_fault_o, 1'b1)
    rd(16'hF470, d);
    `CHK(d, 16'h0001)
    wr(16'hF470, 16'h0001);
    rd(16'hF470, d);
    `CHK(d, 16'h0000)
    wr(16'hF471, 16'h0007);
    wr(16'hF451, 16'h0003);
    wr(16'hF450, 16'h0001);
    frames(2, 1'b0);
    frames(1, 1'b1);
    `CHK(irq_o, 1'b1)
    wr(16'hF471, 16'h0002);
    tick(2);
    `CHK(irq_o, 1'b0)
    frames(2, 1'b0);
    frames(1, 1'b1);
    wr(16'hF472, 16'h0000);
    tick(2);
    `CHK(irq_o, 1'b0)
    wr(16'hF450, 16'h0000);
    frames(3, 1'b0);
    SEQ.sw_err(16'hA5C3);
    rd(16'hF432, d);
    `CHK(d, 16'hA5C3)
    rd(16'hF471, d);
    `CHK(d, 16'h0006)
    test_done();
  end
endmodule
